/* verilog/ghc_top.sv */
`timescale 1ns/1ps
module ghc_top #(
	parameter bit NATIVE_ONLY      = 1'b0,
	parameter bit STAGGERED_SPINUP = 1'b0
) (
	input  wire logic                          clk_i,
	input  wire logic                          rst_i,
	input  wire logic                          wb_cyc_i,
	input  wire logic                          wb_stb_i,
	input  wire logic                          wb_we_i,
	input  wire logic [7:0]                    wb_adr_i,
	input  wire logic [3:0]                    wb_sel_i,
	input  wire logic [31:0]                   wb_dat_i,
	output logic      [31:0]                   wb_dat_o,
	output logic                               wb_ack_o,
	input  wire logic [ghc_pkg::MSI_CNT_W-1:0] msi_req_count_i,
	input  wire logic [ghc_pkg::MSI_CNT_W-1:0] msi_enabled_count_i,
	input  wire logic                          msi_enable_i,
	input  wire logic                          revert_request_i,
	input  wire logic [ghc_pkg::PORTS-1:0]     port_irq_pending_i,
	output logic                               native_mode_enable_o,
	output logic                               native_cmd_enable_o,
	output logic                               single_vector_o,
	output logic                               engine_idle_req_o,
	output logic                               port_comreset_o,
	output logic                               irq_o
);

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------

	// Merges write data into a word under the byte enables.
	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++)
		begin
			if (sel[i])
				res[i*8 +: 8] = new_v[i*8 +: 8];
		end
		return res;
	endfunction : merge_bytes

	// True when the bus addresses the given register offset.
	function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
		return (adr[7:2] == ofs[7:2]);
	endfunction : hit

	// ----------------------------------------------------------------
	// Wishbone slave decode
	// ----------------------------------------------------------------
	logic        ack_q;
	logic [31:0] dat_q;
	logic        irq_q;
	logic        native_q, native_d;
	logic        girq_q, girq_d;
	logic        revert_q, revert_d;
	logic        soft_rst_q, soft_rst_d;
	logic [ghc_pkg::EVT_W-1:0] evt_sts_q, evt_sts_d;
	logic [ghc_pkg::EVT_W-1:0] evt_en_q, evt_en_d;
	logic        fis_q;

	// A request is answered one cycle after it is seen; a write lands on the edge that samples ack.
	wire         req        = wb_cyc_i & wb_stb_i;
	wire         rd_phase   = req & ~ack_q;
	wire         wr_commit  = req & ack_q & wb_we_i;
	wire [31:0]  wr_word    = merge_bytes(32'h0000_0000, wb_dat_i, wb_sel_i);
	wire         wr_ghc     = wr_commit & hit(wb_adr_i, ghc_pkg::OFS_GLOBAL_CTRL);
	wire         wr_evt_en  = wr_commit & hit(wb_adr_i, ghc_pkg::OFS_EVT_ENABLE);
	wire         wr_evt_clr = wr_commit & hit(wb_adr_i, ghc_pkg::OFS_EVT_CLEAR);

	// Assembled register views; every bit not named here reads as zero.
	wire [31:0]  cap_word   = 32'(NATIVE_ONLY) << ghc_pkg::BIT_NATIVE_ONLY;
	wire [31:0]  ghc_word   = (32'(native_q)   << ghc_pkg::BIT_NATIVE_EN)
	                        | (32'(revert_q)   << ghc_pkg::BIT_REVERT)
	                        | (32'(girq_q)     << ghc_pkg::BIT_GIRQ_EN)
	                        | (32'(soft_rst_q) << ghc_pkg::BIT_SOFT_RESET);
	wire [31:0]  sts_word   = 32'(evt_sts_q);
	wire [31:0]  en_word    = 32'(evt_en_q);

	// Read multiplexer; unmapped and write-only addresses answer zero.
	wire [31:0]  rd_word    = hit(wb_adr_i, ghc_pkg::OFS_CAPABILITY)  ? cap_word :
	                          hit(wb_adr_i, ghc_pkg::OFS_GLOBAL_CTRL) ? ghc_word :
	                          hit(wb_adr_i, ghc_pkg::OFS_EVT_STATUS)  ? sts_word :
	                          hit(wb_adr_i, ghc_pkg::OFS_EVT_ENABLE)  ? en_word  :
	                          ghc_pkg::RST_DATA;

	// ----------------------------------------------------------------
	// Soft reset sequencer
	// ----------------------------------------------------------------
	ghc_rst_if rs_if ();

	ghc_reset_seq #(
		.STAGGERED_SPINUP (STAGGERED_SPINUP)
	) u_reset_seq (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.rs    (rs_if.seq)
	);

	// Writing one starts the sequence; writing zero is ignored.
	wire         hr_write   = wr_ghc & wb_sel_i[0] & wb_dat_i[ghc_pkg::BIT_SOFT_RESET];
	assign rs_if.start      = soft_rst_q & ~rs_if.busy & ~rs_if.done;

	// ----------------------------------------------------------------
	// Global control fields
	// ----------------------------------------------------------------

	// Fallback is allowed only with both counts nonzero, unequal and MSI on.
	wire         revert_ok  = (msi_req_count_i != '0) & (msi_enabled_count_i != '0)
	                        & (msi_enabled_count_i != msi_req_count_i) & msi_enable_i;

	// Native enable is writable only when a legacy interface exists.
	assign native_d = NATIVE_ONLY ? 1'b1 :
	                  (wr_ghc & wb_sel_i[3]) ? wr_word[ghc_pkg::BIT_NATIVE_EN] : native_q;
	assign girq_d   = (wr_ghc & wb_sel_i[0]) ? wr_word[ghc_pkg::BIT_GIRQ_EN] : girq_q;

	// Flag sets on the hardware request while allowed, then holds until allowed no longer, and drops as soon as it is not.
	assign revert_d = revert_ok & (revert_q | revert_request_i);

	// Bit stays set from the accepted write until the sequencer reports done.
	assign soft_rst_d = hr_write ? 1'b1 : (rs_if.done ? 1'b0 : soft_rst_q);

	// ----------------------------------------------------------------
	// Event status, enable and interrupt
	// ----------------------------------------------------------------

	// Events raised this cycle; a set in the clearing cycle survives the clear.
	wire [ghc_pkg::EVT_W-1:0] evt_set = {
		native_d != native_q,
		revert_d & ~revert_q,
		rs_if.done
	};
	wire [ghc_pkg::EVT_W-1:0] evt_clr = wr_evt_clr ? wr_word[ghc_pkg::EVT_W-1:0] : ghc_pkg::RST_EVT;

	assign evt_sts_d = (evt_sts_q & ~evt_clr) | evt_set;
	assign evt_en_d  = wr_evt_en ? wr_word[ghc_pkg::EVT_W-1:0] : evt_en_q;

	// Every source, port or own event, is blocked while the global enable is clear.
	wire         irq_d      = girq_q & ((|port_irq_pending_i) | (|(evt_sts_q & evt_en_q)));

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------

	// Bus answer and read data.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_q <= 1'b0;
			dat_q <= ghc_pkg::RST_DATA;
		end
		else
		begin
			ack_q <= rd_phase;
			dat_q <= rd_phase ? rd_word : dat_q;
		end
	end

	// Global control bits.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			native_q   <= NATIVE_ONLY;
			girq_q     <= ghc_pkg::RST_GIRQ_EN;
			revert_q   <= ghc_pkg::RST_REVERT;
			soft_rst_q <= ghc_pkg::RST_SOFT_RST;
		end
		else
		begin
			native_q   <= native_d;
			girq_q     <= girq_d;
			revert_q   <= revert_d;
			soft_rst_q <= soft_rst_d;
		end
	end

	// Event bits, interrupt and native path gate.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			evt_sts_q <= ghc_pkg::RST_EVT;
			evt_en_q  <= ghc_pkg::RST_EVT;
			irq_q     <= 1'b0;
			fis_q     <= 1'b0;
		end
		else
		begin
			evt_sts_q <= evt_sts_d;
			evt_en_q  <= evt_en_d;
			irq_q     <= irq_d;
			fis_q     <= native_q & ~soft_rst_q;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign wb_ack_o             = ack_q;
	assign wb_dat_o             = dat_q;
	assign native_mode_enable_o = native_q;
	assign native_cmd_enable_o  = fis_q;
	assign single_vector_o      = revert_q;
	assign engine_idle_req_o    = rs_if.idle_req;
	assign port_comreset_o      = rs_if.comreset;
	assign irq_o                = irq_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// A held request gets one ack, then ack drops.
	sequence s_bus_answer;
		wb_ack_o ##1 !wb_ack_o;
	endsequence

	sequence s_hr_write;
		wr_ghc && wb_sel_i[0] && wb_dat_i[ghc_pkg::BIT_SOFT_RESET];
	endsequence

	sequence s_quiesce;
		engine_idle_req_o [*5];
	endsequence

	// First stretch of the link reset that follows the quiesce phase.
	sequence s_link_run;
		port_comreset_o [*8];
	endsequence

	AST_BUS_ACK: assert property ($rose(req) && !ack_q |=> s_bus_answer)
		else $error("Bus request not answered after one cycle.");

	AST_NATIVE_RO: assert property (NATIVE_ONLY |-> native_mode_enable_o)
		else $error("Native enable dropped although read-only.");

	AST_NATIVE_GATE: assert property (!native_mode_enable_o |=> !native_cmd_enable_o)
		else $error("Native path active while native enable clear.");

	AST_REVERT_ONLY_OK: assert property ($rose(single_vector_o) |-> $past(revert_ok))
		else $error("Revert flag set without its conditions.");

	AST_REVERT_DROP: assert property (!revert_ok |=> !single_vector_o)
		else $error("Revert flag kept after a condition failed.");

	AST_IRQ_BLOCK: assert property (!girq_q |=> !irq_o)
		else $error("Interrupt raised while global enable clear.");

	AST_IRQ_PORT: assert property (girq_q && (|port_irq_pending_i) |=> irq_o)
		else $error("Enabled port interrupt not raised.");

	AST_HR_START: assert property ((s_hr_write and !soft_rst_q) |=> soft_rst_q ##1 s_quiesce ##1 !engine_idle_req_o)
		else $error("Soft reset did not idle the engines.");

	AST_HR_CLEAR: assert property (rs_if.done |=> !soft_rst_q)
		else $error("Soft reset bit not cleared after completion.");

	// The bit stays set until the sequencer reports that it is done.
	AST_HR_HOLD: assert property (soft_rst_q && !rs_if.done |=> soft_rst_q)
		else $error("Soft reset bit dropped before completion.");

	// Without staggered spin-up the quiesce phase is followed by link reset.
	AST_HR_SEQ: assert property ((s_hr_write and !soft_rst_q and !STAGGERED_SPINUP)
		|=> soft_rst_q ##1 s_quiesce ##1 s_link_run)
		else $error("Soft reset did not reach link reset on all ports.");

	// Link reset starts in the cycle in which the quiesce phase ends.
	AST_HR_LINK: assert property ($fell(engine_idle_req_o) && !STAGGERED_SPINUP |-> port_comreset_o)
		else $error("Link reset did not follow the quiesce phase.");

	// Nothing is posted or issued while the engines are held idle or the links reset.
	AST_CMD_OFF_IDLE: assert property (engine_idle_req_o || port_comreset_o |-> !native_cmd_enable_o)
		else $error("Native path active during soft reset.");

	// A write through the top byte lane loads the written value into the enable when it is writable.
	AST_NATIVE_WR: assert property (wr_ghc && wb_sel_i[3] && !NATIVE_ONLY
		|=> native_mode_enable_o == $past(wb_dat_i[ghc_pkg::BIT_NATIVE_EN]))
		else $error("Native enable did not take the written value.");

	// A change of the enable is recorded in the event status in the same cycle.
	AST_NATIVE_CHG_EVT: assert property ($changed(native_mode_enable_o) |-> evt_sts_q[ghc_pkg::EVT_NATIVE_CHG])
		else $error("Native enable change not recorded.");

	// Programmed single-vector operation is never reported as a fallback.
	AST_REVERT_MSI_ZERO: assert property (msi_enable_i && (msi_enabled_count_i == '0) |=> !single_vector_o)
		else $error("Revert flag set with an enabled count of zero.");

	// An enabled own event raises the interrupt while the global enable is set.
	AST_IRQ_EVT: assert property (girq_q && (|(evt_sts_q & evt_en_q)) |=> irq_o)
		else $error("Enabled event interrupt not raised.");

	// The write-only clear register reads as zero.
	AST_WO_READ_ZERO: assert property (wb_ack_o && !wb_we_i && hit(wb_adr_i, ghc_pkg::OFS_EVT_CLEAR)
		|-> wb_dat_o == 32'h0000_0000)
		else $error("Write-only register read nonzero.");

	AST_HR_ZERO: assert property (wr_ghc && !wb_dat_i[ghc_pkg::BIT_SOFT_RESET] && !soft_rst_q |=> !soft_rst_q)
		else $error("Writing zero started a soft reset.");

	AST_RSVD_ZERO: assert property (wb_ack_o && !wb_we_i && hit(wb_adr_i, ghc_pkg::OFS_GLOBAL_CTRL)
		|-> wb_dat_o[30:3] == 28'h000_0000)
		else $error("Reserved control bits read nonzero.");

	AST_EVT_SET_WINS: assert property (evt_set[0] |=> evt_sts_q[0])
		else $error("Event lost in its clearing cycle.");

endmodule : ghc_top

/* shared/ghc_pkg.sv */
package ghc_pkg;

	// ----------------------------------------------------------------
	// Register map, byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CAPABILITY   = 8'h00;
	localparam logic [7:0] OFS_GLOBAL_CTRL  = 8'h04;
	localparam logic [7:0] OFS_EVT_STATUS   = 8'h20;
	localparam logic [7:0] OFS_EVT_ENABLE   = 8'h24;
	localparam logic [7:0] OFS_EVT_CLEAR    = 8'h28;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int BIT_NATIVE_ONLY  = 18;
	localparam int BIT_NATIVE_EN    = 31;
	localparam int BIT_REVERT       = 2;
	localparam int BIT_GIRQ_EN      = 1;
	localparam int BIT_SOFT_RESET   = 0;
	localparam int EVT_RESET_DONE   = 0;
	localparam int EVT_REVERT_SET   = 1;
	localparam int EVT_NATIVE_CHG   = 2;
	localparam int EVT_W            = 3;
	localparam int PORTS            = 4;
	localparam int MSI_CNT_W        = 3;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [31:0]      RST_DATA      = 32'h0000_0000;
	localparam logic [EVT_W-1:0] RST_EVT       = 3'h0;
	localparam logic             RST_GIRQ_EN   = 1'b0;
	localparam logic             RST_REVERT    = 1'b0;
	localparam logic             RST_SOFT_RST  = 1'b0;

	// ----------------------------------------------------------------
	// Timing, figures in ns and derived cycle counts
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS  = 40;
	localparam int QUIESCE_NS     = 200;
	localparam int COMRESET_NS    = 1000;
	localparam int QUIESCE_CYC    = (QUIESCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int COMRESET_CYC   = (COMRESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W          = 8;

	// Soft reset sequencer states.
	typedef enum logic [1:0] {
		RS_IDLE,
		RS_QUIESCE,
		RS_LINK_RESET,
		RS_FINISH
	} ghc_rst_state_e;

endpackage : ghc_pkg

/* shared/ghc_rst_if.sv */
`timescale 1ns/1ps
// Control path between the register bank and the soft reset sequencer.
interface ghc_rst_if;
	logic start;
	logic busy;
	logic done;
	logic idle_req;
	logic comreset;

	modport ctl
	(
		output start,
		input  busy,
		input  done,
		input  idle_req,
		input  comreset
	);

	modport seq
	(
		input  start,
		output busy,
		output done,
		output idle_req,
		output comreset
	);
endinterface : ghc_rst_if

/* verilog/ghc_reset_seq.sv */
`timescale 1ns/1ps
module ghc_reset_seq #(
	parameter bit STAGGERED_SPINUP = 1'b0
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	ghc_rst_if.seq    rs
);

	// ----------------------------------------------------------------
	// Sequencer state
	// ----------------------------------------------------------------
	ghc_pkg::ghc_rst_state_e state_q, state_d;
	logic [ghc_pkg::CNT_W-1:0] cnt_q, cnt_d;
	logic busy_q, done_q, idle_q, comreset_q;

	// Quiesce transfer engines, then, without staggered spin-up, pulse link reset on every port.
	always_comb
	begin
		state_d = state_q;
		cnt_d   = cnt_q;
		unique case (state_q)
			ghc_pkg::RS_IDLE:
				if (rs.start)
				begin
					state_d = ghc_pkg::RS_QUIESCE;
					cnt_d   = ghc_pkg::CNT_W'(ghc_pkg::QUIESCE_CYC - 1);
				end
			ghc_pkg::RS_QUIESCE:
				if (cnt_q != '0)
					cnt_d = cnt_q - 1'b1;
				else if (STAGGERED_SPINUP)
					state_d = ghc_pkg::RS_FINISH;
				else
				begin
					state_d = ghc_pkg::RS_LINK_RESET;
					cnt_d   = ghc_pkg::CNT_W'(ghc_pkg::COMRESET_CYC - 1);
				end
			ghc_pkg::RS_LINK_RESET:
				if (cnt_q != '0)
					cnt_d = cnt_q - 1'b1;
				else
					state_d = ghc_pkg::RS_FINISH;
			ghc_pkg::RS_FINISH:
				state_d = ghc_pkg::RS_IDLE;
		endcase
	end

	// State and registered outputs.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_q    <= ghc_pkg::RS_IDLE;
			cnt_q      <= '0;
			busy_q     <= 1'b0;
			done_q     <= 1'b0;
			idle_q     <= 1'b0;
			comreset_q <= 1'b0;
		end
		else
		begin
			state_q    <= state_d;
			cnt_q      <= cnt_d;
			busy_q     <= (state_d != ghc_pkg::RS_IDLE);
			done_q     <= (state_d == ghc_pkg::RS_FINISH);
			idle_q     <= (state_d == ghc_pkg::RS_QUIESCE);
			comreset_q <= (state_d == ghc_pkg::RS_LINK_RESET);
		end
	end

	assign rs.busy     = busy_q;
	assign rs.done     = done_q;
	assign rs.idle_req = idle_q;
	assign rs.comreset = comreset_q;

	// Link reset lasts exactly 25 cycles: three runs of eight, one more, then low.
	sequence s_comreset_run;
		rs.comreset [*8];
	endsequence

	AST_COMRESET_LEN: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(rs.comreset) |-> s_comreset_run ##1 s_comreset_run ##1 s_comreset_run ##1 rs.comreset ##1 !rs.comreset)
		else $error("Link reset pulse has the wrong length.");

endmodule : ghc_reset_seq

/* tb/ghc_tb.sv */
`timescale 1ns/1ps
module testbench;
	// ----------------------------------------------------------------
	// Stimulus, observed signals and bookkeeping
	// ----------------------------------------------------------------
	typedef struct {logic [7:0] adr; logic [3:0] sel; logic [31:0] dat; logic [31:0] exp;} ghc_tb_row_s;
	logic        clk_i            = 1'b0;
	logic        rst_i            = 1'b1;
	logic        wb_cyc_i         = 1'b0;
	logic        wb_stb_i         = 1'b0;
	logic        wb_we_i          = 1'b0;
	logic [7:0]  wb_adr_i         = 8'h00;
	logic [3:0]  wb_sel_i         = 4'h0;
	logic [31:0] wb_dat_i         = 32'h0000_0000;
	logic [2:0]  req_cnt          = 3'h0;
	logic [2:0]  en_cnt           = 3'h0;
	logic        msi_on           = 1'b0;
	logic        revert_req       = 1'b0;
	logic [3:0]  pending          = 4'h0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        native_mode_enable_o;
	logic        native_cmd_enable_o;
	logic        single_vector_o;
	logic        engine_idle_req_o;
	logic        port_comreset_o;
	logic        irq_o;
	logic [31:0] idle_cyc         = 32'h0000_0000;
	logic [31:0] com_cyc          = 32'h0000_0000;
	logic [31:0] bad_cmd          = 32'h0000_0000;
	int          n_fail           = 0;
	int          check_count      = 0;
	int          cycles           = 0;
	// Reserved bits, a read-only field, a partial lane write, unmapped and write-only places.
	ghc_tb_row_s rows [8] = '{
		'{8'h04, 4'hF, 32'h8000_0002, 32'h8000_0002},
		'{8'h04, 4'hF, 32'hFFFF_FFFE, 32'h8000_0002},
		'{8'h04, 4'h7, 32'h0000_0000, 32'h8000_0000},
		'{8'h00, 4'hF, 32'hFFFF_FFFF, 32'h0000_0000},
		'{8'h40, 4'hF, 32'hFFFF_FFFF, 32'h0000_0000},
		'{8'h24, 4'hF, 32'h0000_0007, 32'h0000_0007},
		'{8'h28, 4'hF, 32'h0000_0007, 32'h0000_0000},
		'{8'h04, 4'hF, 32'h0000_0000, 32'h0000_0000}};

	ghc_top i_ghc_top (
		.clk_i               (clk_i),
		.rst_i               (rst_i),
		.wb_cyc_i            (wb_cyc_i),
		.wb_stb_i            (wb_stb_i),
		.wb_we_i             (wb_we_i),
		.wb_adr_i            (wb_adr_i),
		.wb_sel_i            (wb_sel_i),
		.wb_dat_i            (wb_dat_i),
		.wb_dat_o            (wb_dat_o),
		.wb_ack_o            (wb_ack_o),
		.msi_req_count_i     (req_cnt),
		.msi_enabled_count_i (en_cnt),
		.msi_enable_i        (msi_on),
		.revert_request_i    (revert_req),
		.port_irq_pending_i  (pending),
		.native_mode_enable_o(native_mode_enable_o),
		.native_cmd_enable_o (native_cmd_enable_o),
		.single_vector_o     (single_vector_o),
		.engine_idle_req_o   (engine_idle_req_o),
		.port_comreset_o     (port_comreset_o),
		.irq_o               (irq_o)
	);

	// The clock toggles every 20 ns, half of its 40 ns period.
	always #20 clk_i = ~clk_i;

	// Counts soft reset phases and cuts a hung run short.
	always @(posedge clk_i)
	begin
		cycles <= cycles + 1;
		idle_cyc <= idle_cyc + 32'(engine_idle_req_o);
		com_cyc <= com_cyc + 32'(port_comreset_o);
		bad_cmd <= bad_cmd + 32'(engine_idle_req_o & native_cmd_enable_o);
		if (cycles == 5000)
		begin
			n_fail++;
			stop_test();
		end
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	// Prints the counts and the verdict, then ends the run.
	task automatic stop_test;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : stop_test

	// Compares a word result.
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			n_fail++;
		end
	endtask : chk_word

	// Compares a single output bit.
	task automatic chk_bit(input logic got, input logic exp);
		check_count++;
		if (got !== exp)
		begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			n_fail++;
		end
	endtask : chk_bit

	// One classic bus cycle, held until ack is sampled high.
	task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel,
		input logic [31:0] dat, output logic [31:0] rd);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= sel;
		wb_dat_i <= dat;
		do
			@(posedge clk_i);
		while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask : wb_xfer

	// Full-word write.
	task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
		logic [31:0] rd;
		wb_xfer(1'b1, adr, 4'hF, dat, rd);
	endtask : wr

	// Read and compare.
	task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
		logic [31:0] rd;
		wb_xfer(1'b0, adr, 4'hF, 32'h0000_0000, rd);
		chk_word(rd, exp);
	endtask : rd_chk

	// Lets registered outputs follow a change.
	task automatic settle;
		repeat (3) @(posedge clk_i);
	endtask : settle

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		logic [31:0] rd;
		int          k;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		rd_chk(8'h04, 32'h0000_0000);
		chk_bit(native_mode_enable_o, 1'b0);
		chk_bit(native_cmd_enable_o, 1'b0);
		chk_bit(single_vector_o, 1'b0);
		chk_bit(irq_o, 1'b0);
		$display("test reset done");
		foreach (rows[i])
		begin
			wb_xfer(1'b1, rows[i].adr, rows[i].sel, rows[i].dat, rd);
			rd_chk(rows[i].adr, rows[i].exp);
		end
		$display("test table done");
		wr(8'h04, 32'h8000_0000);
		settle();
		chk_bit(native_mode_enable_o, 1'b1);
		chk_bit(native_cmd_enable_o, 1'b1);
		chk_word(idle_cyc, 32'h0000_0000);
		$display("test native done");
		req_cnt <= 3'h4;
		en_cnt <= 3'h2;
		msi_on <= 1'b1;
		revert_req <= 1'b1;
		settle();
		chk_bit(single_vector_o, 1'b1);
		rd_chk(8'h04, 32'h8000_0004);
		en_cnt <= 3'h4;
		settle();
		chk_bit(single_vector_o, 1'b0);
		en_cnt <= 3'h2;
		settle();
		chk_bit(single_vector_o, 1'b1);
		en_cnt <= 3'h0;
		settle();
		chk_bit(single_vector_o, 1'b0);
		req_cnt <= 3'h0;
		en_cnt <= 3'h2;
		settle();
		chk_bit(single_vector_o, 1'b0);
		revert_req <= 1'b0;
		$display("test revert done");
		wr(8'h28, 32'h0000_0007);
		wr(8'h04, 32'h8000_0001);
		rd_chk(8'h04, 32'h8000_0001);
		k = 0;
		do
		begin
			wb_xfer(1'b0, 8'h04, 4'hF, 32'h0000_0000, rd);
			k++;
		end
		while (rd[0] !== 1'b0 && k < 40);
		chk_word(rd, 32'h8000_0000);
		chk_word(idle_cyc, 32'(ghc_pkg::QUIESCE_CYC));
		chk_word(com_cyc, 32'(ghc_pkg::COMRESET_CYC));
		chk_word(bad_cmd, 32'h0000_0000);
		rd_chk(8'h20, 32'h0000_0001);
		$display("test soft reset done");
		wr(8'h04, 32'h8000_0002);
		wr(8'h24, 32'h0000_0001);
		settle();
		chk_bit(irq_o, 1'b1);
		wr(8'h24, 32'h0000_0000);
		settle();
		chk_bit(irq_o, 1'b0);
		wr(8'h24, 32'h0000_0001);
		wr(8'h28, 32'h0000_0001);
		settle();
		chk_bit(irq_o, 1'b0);
		pending <= 4'h4;
		settle();
		chk_bit(irq_o, 1'b1);
		wr(8'h04, 32'h8000_0000);
		settle();
		chk_bit(irq_o, 1'b0);
		pending <= 4'h0;
		$display("test interrupt done");
		stop_test();
	end
endmodule : testbench
